// ### common/metering_regs_pkg.sv
// Register map, field formats and carrier types of the harmonic offset and rms register slice.
package metering_regs_pkg;

    localparam int DATA_W = 32;
    localparam int IDX_W = 16;
    localparam int OFFSET_W = 24;
    localparam int RUN_W = 16;
    localparam int NUM_OFFSETS = 10;
    localparam int NUM_RMS = 7;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [IDX_W-1:0] IDX_HARM_Z_ACTIVE_PWR_OFFSET = 16'h43B0;
    localparam logic [IDX_W-1:0] IDX_HARM_X_REACTIVE_PWR_OFFSET = 16'h43B1;
    localparam logic [IDX_W-1:0] IDX_HARM_Y_REACTIVE_PWR_OFFSET = 16'h43B2;
    localparam logic [IDX_W-1:0] IDX_HARM_Z_REACTIVE_PWR_OFFSET = 16'h43B3;
    localparam logic [IDX_W-1:0] IDX_HARM_X_CURRENT_RMS_OFFSET = 16'h43B4;
    localparam logic [IDX_W-1:0] IDX_HARM_Y_CURRENT_RMS_OFFSET = 16'h43B5;
    localparam logic [IDX_W-1:0] IDX_HARM_Z_CURRENT_RMS_OFFSET = 16'h43B6;
    localparam logic [IDX_W-1:0] IDX_HARM_X_VOLTAGE_RMS_OFFSET = 16'h43B7;
    localparam logic [IDX_W-1:0] IDX_HARM_Y_VOLTAGE_RMS_OFFSET = 16'h43B8;
    localparam logic [IDX_W-1:0] IDX_HARM_Z_VOLTAGE_RMS_OFFSET = 16'h43B9;
    localparam logic [IDX_W-1:0] IDX_RSVD_GAP_FIRST = 16'h43BA;
    localparam logic [IDX_W-1:0] IDX_RSVD_GAP_LAST = 16'h43BF;
    localparam logic [IDX_W-1:0] IDX_PHASE_A_CURRENT_RMS = 16'h43C0;
    localparam logic [IDX_W-1:0] IDX_PHASE_A_VOLTAGE_RMS = 16'h43C1;
    localparam logic [IDX_W-1:0] IDX_PHASE_B_CURRENT_RMS = 16'h43C2;
    localparam logic [IDX_W-1:0] IDX_PHASE_B_VOLTAGE_RMS = 16'h43C3;
    localparam logic [IDX_W-1:0] IDX_PHASE_C_CURRENT_RMS = 16'h43C4;
    localparam logic [IDX_W-1:0] IDX_PHASE_C_VOLTAGE_RMS = 16'h43C5;
    localparam logic [IDX_W-1:0] IDX_NEUTRAL_CURRENT_RMS = 16'h43C6;
    localparam logic [IDX_W-1:0] IDX_PHASE_CURRENT_SUM = 16'h43C7;
    localparam logic [IDX_W-1:0] IDX_RSVD_TAIL_FIRST = 16'h43C8;
    localparam logic [IDX_W-1:0] IDX_RSVD_TAIL_LAST = 16'h43FF;
    localparam logic [IDX_W-1:0] IDX_RSVD_DSP_WORD = 16'hE203;
    localparam logic [IDX_W-1:0] IDX_DSP_RUN_CONTROL = 16'hE228;

    localparam logic [OFFSET_W-1:0] OFFSET_RESET = 24'h000000;
    localparam logic [OFFSET_W-1:0] RESULT_RESET = 24'h000000;
    localparam logic [RUN_W-1:0] RUN_RESET = 16'h0000;
    localparam int RUN_ENABLE_BIT = 0;

    // Padding of the serial word formats.
    localparam logic [3:0] ZPSE_PAD = 4'h0;
    localparam logic [7:0] ZP_PAD = 8'h00;
    localparam logic [15:0] RUN_PAD = 16'h0000;

    typedef logic [NUM_OFFSETS-1:0][OFFSET_W-1:0] offset_bank_type;

    // Last field is lane 0, so phase A current lands at the lowest result slot.
    typedef struct packed {
        logic signed [OFFSET_W-1:0] neutralCurrent;
        logic signed [OFFSET_W-1:0] phaseCVoltage;
        logic signed [OFFSET_W-1:0] phaseCCurrent;
        logic signed [OFFSET_W-1:0] phaseBVoltage;
        logic signed [OFFSET_W-1:0] phaseBCurrent;
        logic signed [OFFSET_W-1:0] phaseAVoltage;
        logic signed [OFFSET_W-1:0] phaseACurrent;
    } rms_results_type;

    typedef struct packed {
        logic signed [OFFSET_W-1:0] phaseC;
        logic signed [OFFSET_W-1:0] phaseB;
        logic signed [OFFSET_W-1:0] phaseA;
    } current_samples_type;

endpackage

// ### logic/harmonic_offset_rms_regs.sv
// APB register slice for harmonic offsets, rms results, current sum and signal processor run.
// Overview of operation
// RL1 - Offset registers read as four zero bits, four sign copies, then 24 data bits.
// RL2 - Rms and sum results read with the upper eight bits zero.
// RL3 - Signed registers hold two's complement values; unsigned ones plain binary.
// RL4 - Harmonic Z active power offset is 24-bit signed read-write, reset zero.
// RL5 - Three reactive power offsets follow it, 24-bit signed read-write, reset zero.
// RL6 - Three current rms offsets, 24-bit signed read-write, reset zero.
// RL7 - Three voltage rms offsets, 24-bit signed read-write, reset zero.
// RL8 - Phase current and voltage rms results alternate at consecutive read-only addresses.
// RL9 - Neutral current rms result sits right after phase C voltage rms.
// RL10 - Current-sum register holds the sum of the three phase current samples.
// RL11 - Software must not write the reserved ranges around the rms results.
// RL12 - Software must not write the reserved 16-bit processor memory word.
// RL13 - A 16-bit run control register, reset zero, starts and stops the processor.
// RL14 - Per-phase current sample holds the latest signed 24-bit waveform value.
// RL15 - Writes to read-only rms or current-sum registers are ignored.
`timescale 1ns/1ps
`default_nettype none

module harmonic_offset_rms_regs
    import metering_regs_pkg::*;
#(
    parameter int ADDR_W = IDX_W + 2
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rms_results_type rmsResults,
    input wire logic rmsValid,
    input wire current_samples_type currentSamples,
    input wire logic sampleValid,
    output offset_bank_type harmOffsets,
    output logic [RUN_W-1:0] runControl,
    output logic dspRun
);

    logic [IDX_W-1:0] regIdx;
    logic aligned;
    logic setupPhase;
    logic accessDone;
    logic writeDone;
    logic isOffset;
    logic isResult;
    logic isRun;
    logic isReserved;
    logic [3:0] offIdx;
    logic [2:0] resIdx;
    logic [DATA_W-1:0] rawWord;
    logic [DATA_W-1:0] nxt_prdata;
    logic [DATA_W-1:0] nxt_wrWord;
    logic [OFFSET_W-1:0] nxt_currentSum;
    logic [NUM_RMS-1:0][OFFSET_W-1:0] rmsLanes;

    offset_bank_type offsetRegs_ff;
    logic [NUM_RMS-1:0][OFFSET_W-1:0] rmsRegs_ff;
    logic [OFFSET_W-1:0] currentSum_ff;
    current_samples_type samples_ff;
    logic [RUN_W-1:0] runControl_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    function automatic logic [DATA_W-1:0] zpse(input logic [OFFSET_W-1:0] v);
        return {ZPSE_PAD, {4{v[OFFSET_W-1]}}, v}; // RL1
    endfunction

    function automatic logic [DATA_W-1:0] mergeBytes(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [3:0] strb
    );
        logic [DATA_W-1:0] w;
        w = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                w[b*8 +: 8] = newWord[b*8 +: 8];
            end
        end
        return w;
    endfunction

    assign regIdx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready_ff;
    assign writeDone = accessDone && pwrite && !pslverr_ff;
    assign offIdx = 4'(regIdx - IDX_HARM_Z_ACTIVE_PWR_OFFSET);
    assign resIdx = 3'(regIdx - IDX_PHASE_A_CURRENT_RMS);

    always_comb begin
        isOffset = 1'b0;
        isResult = 1'b0;
        isRun = 1'b0;
        isReserved = 1'b0;
        if (regIdx >= IDX_HARM_Z_ACTIVE_PWR_OFFSET && regIdx <= IDX_HARM_Z_VOLTAGE_RMS_OFFSET) begin
            isOffset = 1'b1;
        end else if (regIdx >= IDX_PHASE_A_CURRENT_RMS && regIdx <= IDX_PHASE_CURRENT_SUM) begin
            isResult = 1'b1; // RL8 RL9
        end else if (regIdx == IDX_DSP_RUN_CONTROL) begin
            isRun = 1'b1;
        end else if (regIdx >= IDX_RSVD_GAP_FIRST && regIdx <= IDX_RSVD_GAP_LAST) begin
            isReserved = 1'b1; // RL11
        end else if (regIdx >= IDX_RSVD_TAIL_FIRST && regIdx <= IDX_RSVD_TAIL_LAST) begin
            isReserved = 1'b1; // RL11
        end else if (regIdx == IDX_RSVD_DSP_WORD) begin
            isReserved = 1'b1; // RL12
        end
    end

    always_comb begin
        rawWord = '0;
        nxt_prdata = '0;
        if (isOffset && offIdx < 4'(NUM_OFFSETS)) begin
            rawWord = {ZP_PAD, offsetRegs_ff[offIdx]};
            nxt_prdata = zpse(offsetRegs_ff[offIdx]); // RL1
        end else if (isResult && resIdx == 3'(NUM_RMS)) begin
            nxt_prdata = {ZP_PAD, currentSum_ff}; // RL2
        end else if (isResult) begin
            nxt_prdata = {ZP_PAD, rmsRegs_ff[resIdx]}; // RL2
        end else if (isRun) begin
            rawWord = {RUN_PAD, runControl_ff};
            nxt_prdata = {RUN_PAD, runControl_ff};
        end
        nxt_wrWord = mergeBytes(rawWord, pwdata, pstrb);
    end

    // Read data is captured in the setup cycle, so the access phase never waits.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= setupPhase;
            if (setupPhase) begin
                pslverr_ff <= !aligned || !(isOffset || isResult || isRun || isReserved);
                prdata_ff <= pwrite ? '0 : nxt_prdata;
            end
        end
    end

    for (genvar i = 0; i < NUM_OFFSETS; i++) begin : g_offset
        always_ff @(posedge core_clk) begin
            if (reset) begin
                offsetRegs_ff[i] <= OFFSET_RESET; // RL4 RL5 RL6 RL7
            end else if (writeDone && isOffset && offIdx == 4'(i)) begin
                offsetRegs_ff[i] <= nxt_wrWord[OFFSET_W-1:0]; // RL4 RL5 RL6 RL7
            end
        end
    end

    // Results change only on the pipeline strobe; bus writes never reach them.
    assign rmsLanes = rmsResults;
    for (genvar r = 0; r < NUM_RMS; r++) begin : g_rms
        always_ff @(posedge core_clk) begin
            if (reset) begin
                rmsRegs_ff[r] <= RESULT_RESET;
            end else if (rmsValid) begin
                rmsRegs_ff[r] <= rmsLanes[r]; // RL8 RL9 RL15
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            samples_ff <= '0;
        end else if (sampleValid) begin
            samples_ff <= currentSamples; // RL14
        end
    end

    // The sum wraps at 24 bits, the same width software reads back.
    assign nxt_currentSum = samples_ff.phaseA + samples_ff.phaseB + samples_ff.phaseC; // RL3

    always_ff @(posedge core_clk) begin
        if (reset) begin
            currentSum_ff <= RESULT_RESET;
        end else begin
            currentSum_ff <= nxt_currentSum; // RL10
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            runControl_ff <= RUN_RESET; // RL13
        end else if (writeDone && isRun) begin
            runControl_ff <= nxt_wrWord[RUN_W-1:0]; // RL13
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff && pready_ff;
    assign harmOffsets = offsetRegs_ff;
    assign runControl = runControl_ff;
    assign dspRun = runControl_ff[RUN_ENABLE_BIT];

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence s_read_setup;
        setupPhase && !pwrite && aligned;
    endsequence

    sequence s_full_write;
        accessDone && pwrite && pstrb == 4'hF && !pslverr;
    endsequence

    property p_zpse_read;
        s_read_setup and isOffset |=> prdata[31:28] == ZPSE_PAD && prdata[27:24] == {4{prdata[23]}};
    endproperty
    a_zpse_read: assert property (p_zpse_read) else $error("Offset read lacks pad or sign."); // RL1

    property p_zp_read;
        s_read_setup and isResult |=> prdata[31:24] == ZP_PAD;
    endproperty
    a_zp_read: assert property (p_zp_read) else $error("Result read upper byte not zero."); // RL2

    property p_signed_read;
        s_read_setup and isOffset |=> $signed(prdata[27:0]) == $signed($past(rawWord[23:0]));
    endproperty
    a_signed_read: assert property (p_signed_read) else $error("Offset read not sign correct."); // RL3

    property p_active_write;
        s_full_write and regIdx == IDX_HARM_Z_ACTIVE_PWR_OFFSET
            |=> offsetRegs_ff[0] == $past(pwdata[23:0]);
    endproperty
    a_active_write: assert property (p_active_write) else $error("Active offset not written."); // RL4

    property p_reactive_reset;
        $past(reset) |-> offsetRegs_ff[3:1] == '0;
    endproperty
    a_reactive_reset: assert property (p_reactive_reset) else $error("Reactive offsets not zero."); // RL5

    property p_current_offset_hold;
        !(writeDone && isOffset) |=> $stable(offsetRegs_ff[6:4]);
    endproperty
    a_current_offset_hold: assert property (p_current_offset_hold) else $error("Offset moved."); // RL6

    property p_voltage_write;
        s_full_write and regIdx == IDX_HARM_Z_VOLTAGE_RMS_OFFSET
            |=> offsetRegs_ff[9] == $past(pwdata[23:0]);
    endproperty
    a_voltage_write: assert property (p_voltage_write) else $error("Voltage offset not written."); // RL7

    property p_phase_capture;
        rmsValid |=> rmsRegs_ff[0] == $past(rmsResults.phaseACurrent)
            && rmsRegs_ff[1] == $past(rmsResults.phaseAVoltage);
    endproperty
    a_phase_capture: assert property (p_phase_capture) else $error("Phase rms not captured."); // RL8

    property p_neutral_capture;
        rmsValid |=> rmsRegs_ff[6] == $past(rmsResults.neutralCurrent);
    endproperty
    a_neutral_capture: assert property (p_neutral_capture) else $error("Neutral not captured."); // RL9

    property p_current_sum;
        sampleValid |=> ##1 currentSum_ff == OFFSET_W'($past(currentSamples.phaseA, 2)
            + $past(currentSamples.phaseB, 2) + $past(currentSamples.phaseC, 2));
    endproperty
    a_current_sum: assert property (p_current_sum) else $error("Current sum wrong."); // RL10

    property p_run_write;
        s_full_write and isRun |=> runControl == $past(pwdata[15:0]) && dspRun == runControl[0];
    endproperty
    a_run_write: assert property (p_run_write) else $error("Run control not written."); // RL13

    property p_sample_latch;
        sampleValid |=> samples_ff == $past(currentSamples);
    endproperty
    a_sample_latch: assert property (p_sample_latch) else $error("Sample not latched."); // RL14

    property p_ro_ignored;
        accessDone && pwrite && isResult && !rmsValid |=> $stable(rmsRegs_ff);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("Read-only result changed."); // RL15

    property p_zpse_negative;
        s_read_setup and isOffset && offsetRegs_ff[offIdx][OFFSET_W-1] |=> prdata[27:24] == 4'hF;
    endproperty
    a_zpse_negative: assert property (p_zpse_negative) else $error("Negative sign lost."); // RL1

    property p_offset_sign_pos;
        s_read_setup and isOffset && !offsetRegs_ff[offIdx][OFFSET_W-1] |=> prdata[27:24] == 4'h0;
    endproperty
    a_offset_sign_pos: assert property (p_offset_sign_pos) else $error("Positive sign wrong."); // RL3

    property p_sum_read;
        s_read_setup and isResult && resIdx == 3'(NUM_RMS) |=> prdata == {ZP_PAD, $past(currentSum_ff)};
    endproperty
    a_sum_read: assert property (p_sum_read) else $error("Sum read wrong."); // RL2

    property p_rms_read;
        s_read_setup and isResult && resIdx != 3'(NUM_RMS)
            |=> prdata == {ZP_PAD, $past(rmsRegs_ff[resIdx])};
    endproperty
    a_rms_read: assert property (p_rms_read) else $error("Rms read wrong."); // RL2

    property p_run_read;
        s_read_setup and isRun |=> prdata == {RUN_PAD, $past(runControl_ff)};
    endproperty
    a_run_read: assert property (p_run_read) else $error("Run read wrong."); // RL13

    property p_run_hold;
        !(writeDone && isRun) |=> $stable(runControl_ff);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("Run control moved."); // RL13

    property p_active_hold;
        !(writeDone && isOffset && offIdx == 4'h0) |=> $stable(offsetRegs_ff[0]);
    endproperty
    a_active_hold: assert property (p_active_hold) else $error("Active offset moved."); // RL4

    property p_misaligned_drop;
        accessDone && pwrite && !aligned |=> $stable(offsetRegs_ff) && $stable(runControl_ff);
    endproperty
    a_misaligned_drop: assert property (p_misaligned_drop) else $error("Misaligned write landed."); // RL4

    property p_reactive_hold;
        !(writeDone && isOffset && offIdx >= 4'h1 && offIdx <= 4'h3) |=> $stable(offsetRegs_ff[3:1]);
    endproperty
    a_reactive_hold: assert property (p_reactive_hold) else $error("Reactive offset moved."); // RL5

    property p_current_write;
        s_full_write and regIdx == IDX_HARM_X_CURRENT_RMS_OFFSET
            |=> offsetRegs_ff[4] == $past(pwdata[23:0]);
    endproperty
    a_current_write: assert property (p_current_write) else $error("Current offset not written."); // RL6

    property p_voltage_hold;
        !(writeDone && isOffset && offIdx >= 4'h7 && offIdx <= 4'h9) |=> $stable(offsetRegs_ff[9:7]);
    endproperty
    a_voltage_hold: assert property (p_voltage_hold) else $error("Voltage offset moved."); // RL7

    property p_phase_bc_capture;
        rmsValid |=> rmsRegs_ff[2] == $past(rmsResults.phaseBCurrent)
            && rmsRegs_ff[3] == $past(rmsResults.phaseBVoltage)
            && rmsRegs_ff[4] == $past(rmsResults.phaseCCurrent)
            && rmsRegs_ff[5] == $past(rmsResults.phaseCVoltage);
    endproperty
    a_phase_bc_capture: assert property (p_phase_bc_capture) else $error("Phase B or C lost."); // RL8

    property p_rms_hold;
        !rmsValid |=> $stable(rmsRegs_ff);
    endproperty
    a_rms_hold: assert property (p_rms_hold) else $error("Rms result moved."); // RL9

    property p_reserved_read;
        s_read_setup and isReserved |=> prdata == '0 && !pslverr;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("Reserved read not zero."); // RL11

    property p_reserved_quiet;
        accessDone && pwrite && isReserved |=> $stable(offsetRegs_ff) && $stable(runControl_ff);
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet) else $error("Reserved write landed."); // RL11

    property p_dsp_word_no_err;
        accessDone && aligned && regIdx == IDX_RSVD_DSP_WORD |-> !pslverr;
    endproperty
    a_dsp_word_no_err: assert property (p_dsp_word_no_err) else $error("Reserved word error."); // RL12

    property p_ro_no_err;
        accessDone && aligned && isResult |-> !pslverr;
    endproperty
    a_ro_no_err: assert property (p_ro_no_err) else $error("Result access error."); // RL15

    // A held sample keeps the sum steady between pipeline strobes.
    property p_sample_hold;
        !sampleValid |=> $stable(samples_ff);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("Sample moved."); // RL14

endmodule // harmonic_offset_rms_regs

`default_nettype wire

// ### tb/testbench.sv
// Self-checking APB testbench for the harmonic offset and rms register slice.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import metering_regs_pkg::*;

    logic core_clk;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0] pstrb;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    rms_results_type rmsResults;
    logic rmsValid;
    current_samples_type currentSamples;
    logic sampleValid;
    offset_bank_type harmOffsets;
    logic [RUN_W-1:0] runControl;
    logic dspRun;
    int n_mismatch;
    int compares;
    logic [23:0] vals [10];
    logic [23:0] sum;

    harmonic_offset_rms_regs dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rmsResults(rmsResults), .rmsValid(rmsValid),
        .currentSamples(currentSamples), .sampleValid(sampleValid),
        .harmOffsets(harmOffsets), .runControl(runControl), .dspRun(dspRun)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    function automatic logic [17:0] ad(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction

    function automatic logic [31:0] zpse(input logic [23:0] d);
        return {4'h0, {4{d[23]}}, d};
    endfunction

    // One idle edge precedes every setup so psel is never assigned twice in a time step.
    task automatic bus(input logic [17:0] a, input logic w, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready wait", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] st,
                      input logic expErr);
        logic [31:0] rd;
        logic err;
        bus(a, 1'b1, d, st, rd, err);
        check($sformatf("write error %h", a), {31'h0, expErr}, {31'h0, err});
    endtask

    task automatic rdchk(input logic [17:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        bus(a, 1'b0, 32'h0, 4'h0, rd, err);
        check($sformatf("read data %h", a), exp, rd);
        check($sformatf("read error %h", a), 32'h0, {31'h0, err});
    endtask

    initial begin
        n_mismatch = 0;
        compares = 0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        rmsResults = '0;
        rmsValid = 1'b0;
        currentSamples = '0;
        sampleValid = 1'b0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rdchk(ad(IDX_HARM_Z_ACTIVE_PWR_OFFSET + 16'(i)), 32'h0);
        end
        rdchk(ad(IDX_DSP_RUN_CONTROL), 32'h0);
        check("runControl reset", 32'h0, {16'h0, runControl});
        // Alternate near-most positive and near-most negative values to expose sign slips.
        for (int i = 0; i < 10; i++) begin
            vals[i] = (i % 2) ? 24'h800000 + 24'(i) : 24'h7FFFF0 + 24'(i);
            wr(ad(IDX_HARM_Z_ACTIVE_PWR_OFFSET + 16'(i)), {8'hA5, vals[i]}, 4'hF, 1'b0);
        end
        for (int i = 0; i < 10; i++) begin
            rdchk(ad(IDX_HARM_Z_ACTIVE_PWR_OFFSET + 16'(i)), zpse(vals[i]));
            check("harmOffsets lane", {8'h0, vals[i]}, {8'h0, harmOffsets[i]});
        end
        wr(ad(IDX_HARM_X_REACTIVE_PWR_OFFSET), 32'hFFFFFFFF, 4'b0001, 1'b0);
        wr(ad(IDX_HARM_X_REACTIVE_PWR_OFFSET), 32'h00000000, 4'b1000, 1'b0);
        rdchk(ad(IDX_HARM_X_REACTIVE_PWR_OFFSET), 32'h0F8000FF);
        wr(ad(IDX_DSP_RUN_CONTROL), 32'hFFFFA5A5, 4'hF, 1'b0);
        rdchk(ad(IDX_DSP_RUN_CONTROL), 32'h0000A5A5);
        check("dspRun on", 32'h1, {31'h0, dspRun});
        check("runControl value", 32'h0000A5A5, {16'h0, runControl});
        wr(ad(IDX_DSP_RUN_CONTROL), 32'h00000002, 4'hF, 1'b0);
        @(posedge core_clk);
        check("dspRun off", 32'h0, {31'h0, dspRun});
        rdchk(ad(IDX_DSP_RUN_CONTROL), 32'h00000002);
        @(posedge core_clk);
        rmsResults <= {24'h00ABCD, 24'h800001, 24'h123456, 24'hFEDCBA, 24'h000007,
                       24'h7FFFFF, 24'h880000};
        rmsValid <= 1'b1;
        @(posedge core_clk);
        rmsValid <= 1'b0;
        rmsResults <= '0;
        rdchk(ad(IDX_PHASE_A_CURRENT_RMS), 32'h00880000);
        rdchk(ad(IDX_PHASE_A_VOLTAGE_RMS), 32'h007FFFFF);
        rdchk(ad(IDX_PHASE_B_CURRENT_RMS), 32'h00000007);
        rdchk(ad(IDX_PHASE_B_VOLTAGE_RMS), 32'h00FEDCBA);
        rdchk(ad(IDX_PHASE_C_CURRENT_RMS), 32'h00123456);
        rdchk(ad(IDX_PHASE_C_VOLTAGE_RMS), 32'h00800001);
        rdchk(ad(IDX_NEUTRAL_CURRENT_RMS), 32'h0000ABCD);
        wr(ad(IDX_PHASE_A_CURRENT_RMS), 32'h00123456, 4'hF, 1'b0);
        rdchk(ad(IDX_PHASE_A_CURRENT_RMS), 32'h00880000);
        // Samples chosen so the 24-bit sum wraps past the negative limit.
        @(posedge core_clk);
        currentSamples <= {24'h800000, 24'hC00000, 24'h000010};
        sampleValid <= 1'b1;
        @(posedge core_clk);
        sampleValid <= 1'b0;
        currentSamples <= {24'h111111, 24'h222222, 24'h333333};
        sum = 24'h800000 + 24'hC00000 + 24'h000010;
        repeat (3) @(posedge core_clk);
        rdchk(ad(IDX_PHASE_CURRENT_SUM), {8'h0, sum});
        wr(ad(IDX_PHASE_CURRENT_SUM), 32'h0, 4'hF, 1'b0);
        rdchk(ad(IDX_PHASE_CURRENT_SUM), {8'h0, sum});
        wr(ad(IDX_RSVD_GAP_FIRST), 32'hFFFFFFFF, 4'hF, 1'b0);
        rdchk(ad(IDX_RSVD_GAP_LAST), 32'h0);
        wr(ad(IDX_RSVD_TAIL_LAST), 32'hFFFFFFFF, 4'hF, 1'b0);
        rdchk(ad(IDX_RSVD_TAIL_FIRST), 32'h0);
        wr(ad(IDX_RSVD_DSP_WORD), 32'hFFFFFFFF, 4'hF, 1'b0);
        rdchk(ad(IDX_RSVD_DSP_WORD), 32'h0);
        rdchk(ad(IDX_HARM_Z_VOLTAGE_RMS_OFFSET), zpse(vals[9]));
        wr(ad(16'h4000), 32'h1, 4'hF, 1'b1);
        wr(ad(IDX_HARM_Z_ACTIVE_PWR_OFFSET) | 18'h1, 32'h0, 4'hF, 1'b1);
        rdchk(ad(IDX_HARM_Z_ACTIVE_PWR_OFFSET), zpse(vals[0]));
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

endmodule // testbench

`default_nettype wire
